/* hw/ata_sector_write_commands.sv */
// Function
// - Opcode 38H writes sectors skipping the implied erase, same handshake as normal write.
// - A sector not pre-erased gets an ordinary write including the erase.
// - The no-erase write follows the normal multi-sector write protocol exactly.
// - Opcode 3CH writes 1 to 256 sectors counted by the sector-count register.
// - Sector count zero means 256 sectors.
// - Writing starts at the addressed sector and steps through consecutive sectors.
// - On accept: busy first, then data request with busy dropped, then wait.
// - No interrupt announces the first buffer fill.
// - A full sector in the buffer raises busy and drops data request.
// - Buffer ready again: busy drops, data request rises, interrupt raised.
// - After the last sector busy holds until completion, then completion interrupt.
// - An error stops the write at the failing sector.
// - After an error the address registers hold the failing sector.
// - Writes report only bad-block, ID-not-found, aborted, address-mark errors.
// - Unknown opcode reports only aborted with ready, seek and error status.
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module ata_sector_write_commands
  import ata_wr_pkg::*;
#(
  parameter int SECTOR_WORDS = 128,
  parameter int SECTORS_PER_TRACK = 32,
  parameter int HEADS = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Interrupt
  output logic irq_o,
  // Flash write engine
  output logic wr_req_o,
  output logic wr_erase_o,
  output logic wr_chs_o,
  output logic [27:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic wr_data_valid_o,
  input wire logic sector_erased_i,
  input wire logic wr_done_i,
  input wire logic [7:0] wr_err_i
);

  localparam int WC_W = $clog2(SECTOR_WORDS);
  localparam logic [WC_W-1:0] LAST_WORD = WC_W'(SECTOR_WORDS - 1);
  localparam logic [7:0] SPT = 8'(SECTORS_PER_TRACK);
  localparam logic [3:0] LAST_HEAD = 4'(HEADS - 1);

  state_e state;
  state_e next_state;
  logic [7:0] feature;
  logic [7:0] sec_cnt;
  logic [7:0] sec_num;
  logic [7:0] cyl_lo;
  logic [7:0] cyl_hi;
  logic [7:0] drv_head;
  logic [7:0] error_flags;
  logic err_bit;
  logic no_erase;
  logic [8:0] remaining;
  logic [WC_W-1:0] word_cnt;
  logic [IRQ_W-1:0] irq_sts;
  logic [IRQ_W-1:0] irq_mask;
  logic dp_wr;
  logic [3:0] dp_idx;

  // Address phase decode
  wire addr_ok = hsel_i && htrans_i[1] && hready_i;
  wire [3:0] a_idx = haddr_i[IDX_LSB+3:IDX_LSB];
  wire mapped = (haddr_i[31:IDX_LSB+4] == '0) && (a_idx <= IDX_IRQ_MASK);

  // Data phase write strobes
  wire wr_feature = dp_wr && (dp_idx == IDX_FEATURE);
  wire wr_sec_cnt = dp_wr && (dp_idx == IDX_SEC_CNT);
  wire wr_sec_num = dp_wr && (dp_idx == IDX_SEC_NUM);
  wire wr_cyl_lo = dp_wr && (dp_idx == IDX_CYL_LO);
  wire wr_cyl_hi = dp_wr && (dp_idx == IDX_CYL_HI);
  wire wr_drv_head = dp_wr && (dp_idx == IDX_DRV_HEAD);
  wire wr_cmd = dp_wr && (dp_idx == IDX_CMD);
  wire wr_data = dp_wr && (dp_idx == IDX_DATA);
  wire wr_irq_sts = dp_wr && (dp_idx == IDX_IRQ_STS);
  wire wr_irq_mask = dp_wr && (dp_idx == IDX_IRQ_MASK);
  wire [7:0] wbyte = hwdata_i[7:0];

  // Status view; ready and seek-complete always stand, fault never
  wire busy = (state == ST_ACCEPT) || (state == ST_PROG) || (state == ST_DONE);
  wire drq = (state == ST_FILL);
  wire idle = (state == ST_IDLE);
  wire [7:0] status_flags = {busy, 1'b1, 1'b0, 1'b1, drq, 1'b0, 1'b0, err_bit};

  // Command acceptance; task file is only writable while idle
  wire tf_open = idle;
  wire known_op = (wbyte == OP_WR_NO_ERASE) || (wbyte == OP_WR_VERIFY);
  wire go = wr_cmd && idle && known_op;
  wire bad_op = wr_cmd && idle && !known_op;

  // Data words are taken only while data request stands
  wire take_word = wr_data && drq;
  wire sector_full = take_word && (word_cnt == LAST_WORD);
  wire prog_end = (state == ST_PROG) && wr_done_i;
  wire prog_bad = prog_end && ((wr_err_i & WR_ERR_MASK) != '0);
  wire prog_ok = prog_end && !prog_bad;
  wire last_sector = (remaining == ONE_SECTOR);

  // Next address: block mode is a flat increment, CHS walks the geometry
  wire lba_mode = drv_head[DH_LBA];
  wire [27:0] cur_addr = {drv_head[3:0], cyl_hi, cyl_lo, sec_num};
  wire [27:0] lba_next = cur_addr + 28'h0000001;
  wire sec_wrap = (sec_num >= SPT);
  wire head_wrap = (drv_head[3:0] >= LAST_HEAD);
  wire [15:0] cyl_next = {cyl_hi, cyl_lo} + 16'h0001;
  wire [7:0] chs_sec = sec_wrap ? 8'h01 : sec_num + 8'h01;
  wire [3:0] chs_head = !sec_wrap ? drv_head[3:0] : (head_wrap ? 4'h0 : drv_head[3:0] + 4'h1);
  wire [15:0] chs_cyl = (sec_wrap && head_wrap) ? cyl_next : {cyl_hi, cyl_lo};
  wire [27:0] chs_next = {chs_head, chs_cyl, chs_sec};
  wire [27:0] step_addr = lba_mode ? lba_next : chs_next;

  // Interrupt events; the first fill after accept raises none
  wire ev_drq = prog_ok && !last_sector;
  wire ev_done = (state == ST_DONE) || prog_bad || bad_op;
  wire [IRQ_W-1:0] irq_set = {ev_done, ev_drq};
  wire [IRQ_W-1:0] irq_clr = wr_irq_sts ? hwdata_i[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_irq_sts = (irq_sts & ~irq_clr) | irq_set;

  // Read mux evaluated in the address phase, registered for the data phase
  logic [7:0] rd_byte;
  always_comb begin
    case (a_idx)
      IDX_FEATURE: rd_byte = feature;
      IDX_SEC_CNT: rd_byte = sec_cnt;
      IDX_SEC_NUM: rd_byte = sec_num;
      IDX_CYL_LO: rd_byte = cyl_lo;
      IDX_CYL_HI: rd_byte = cyl_hi;
      IDX_DRV_HEAD: rd_byte = drv_head;
      IDX_ERROR: rd_byte = error_flags;
      IDX_STATUS: rd_byte = status_flags;
      IDX_IRQ_STS: rd_byte = 8'(irq_sts);
      IDX_IRQ_MASK: rd_byte = 8'(irq_mask);
      default: rd_byte = 8'h00;
    endcase
  end
  wire [31:0] next_rdata = (addr_ok && !hwrite_i && mapped) ? {24'h000000, rd_byte} : 32'h00000000;

  // Sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (go) next_state = ST_ACCEPT;
      ST_ACCEPT: next_state = ST_FILL;
      ST_FILL: if (sector_full) next_state = ST_PROG;
      ST_PROG: begin
        if (prog_bad) begin
          next_state = ST_IDLE;
        end else if (prog_ok) begin
          next_state = last_sector ? ST_DONE : ST_FILL;
        end
      end
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) state <= ST_IDLE;
    else state <= next_state;
  end

  // Bus data phase capture; zero wait states, always OKAY
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      dp_wr <= 1'b0;
      dp_idx <= IDX_DATA;
      hrdata_o <= 32'h00000000;
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
    end else begin
      dp_wr <= addr_ok && hwrite_i && mapped;
      dp_idx <= a_idx;
      hrdata_o <= next_rdata;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // Task file registers; address fields advance only after a clean sector
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      feature <= 8'h00;
      sec_cnt <= 8'h01;
      sec_num <= 8'h01;
      cyl_lo <= 8'h00;
      cyl_hi <= 8'h00;
      drv_head <= 8'hA0;
    end else if (tf_open) begin
      if (wr_feature) feature <= wbyte;
      if (wr_sec_cnt) sec_cnt <= wbyte;
      if (wr_sec_num) sec_num <= wbyte;
      if (wr_cyl_lo) cyl_lo <= wbyte;
      if (wr_cyl_hi) cyl_hi <= wbyte;
      if (wr_drv_head) drv_head <= wbyte;
    end else if (prog_ok && !last_sector) begin
      // A failed sector leaves the address untouched for the host
      {drv_head[3:0], cyl_hi, cyl_lo, sec_num} <= step_addr;
    end
  end

  // Transfer bookkeeping
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      remaining <= ONE_SECTOR;
      no_erase <= 1'b0;
      word_cnt <= '0;
    end else if (go) begin
      remaining <= (sec_cnt == 8'h00) ? MAX_SECTORS : {1'b0, sec_cnt};
      no_erase <= (wbyte == OP_WR_NO_ERASE);
      word_cnt <= '0;
    end else begin
      if (take_word) word_cnt <= sector_full ? '0 : word_cnt + 1'b1;
      if (prog_ok) remaining <= remaining - ONE_SECTOR;
    end
  end

  // Error reporting; only write-legal codes pass the mask
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      error_flags <= 8'h00;
      err_bit <= 1'b0;
    end else if (go) begin
      error_flags <= 8'h00;
      err_bit <= 1'b0;
    end else if (bad_op) begin
      error_flags <= ABRT_CODE;
      err_bit <= 1'b1;
    end else if (prog_bad) begin
      error_flags <= wr_err_i & WR_ERR_MASK;
      err_bit <= 1'b1;
    end
  end

  // Flash engine hand-off; erase is skipped only when asked and already erased
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_req_o <= 1'b0;
      wr_erase_o <= 1'b1;
      wr_chs_o <= 1'b0;
      wr_addr_o <= 28'h0000000;
      wr_data_o <= 32'h00000000;
      wr_data_valid_o <= 1'b0;
    end else begin
      wr_req_o <= sector_full;
      wr_data_valid_o <= take_word;
      if (take_word) wr_data_o <= hwdata_i;
      if (sector_full) begin
        wr_erase_o <= !(no_erase && sector_erased_i);
        wr_chs_o <= !lba_mode;
        wr_addr_o <= cur_addr;
      end
    end
  end

  // Interrupt status and mask; a new event beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_sts <= '0;
      irq_mask <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_sts <= next_irq_sts;
      if (wr_irq_mask) irq_mask <= hwdata_i[IRQ_W-1:0];
      irq_o <= |(next_irq_sts & (wr_irq_mask ? hwdata_i[IRQ_W-1:0] : irq_mask));
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // Accept path: busy one cycle, then data request
  sequence s_accept;
    (state == ST_ACCEPT) && !drq ##1 drq && !busy;
  endsequence

  // Completion path: busy holds one cycle, then idle with the done flag
  sequence s_finish;
    busy && !drq ##1 idle && irq_sts[IRQ_DONE];
  endsequence

  property p_accept;
    go |=> s_accept;
  endproperty
  a_accept: assert property (p_accept) else $error("accept handshake wrong");

  property p_first_quiet;
    go |=> !ev_drq ##1 !irq_sts[IRQ_DRQ] || $past(irq_sts[IRQ_DRQ], 2);
  endproperty
  a_first_quiet: assert property (p_first_quiet) else $error("irq on first fill");

  property p_full;
    sector_full |=> busy && !drq && wr_req_o;
  endproperty
  a_full: assert property (p_full) else $error("full sector not busy");

  property p_next;
    ev_drq |=> drq && !busy && irq_sts[IRQ_DRQ];
  endproperty
  a_next: assert property (p_next) else $error("next buffer not signalled");

  property p_last;
    prog_ok && last_sector |=> s_finish;
  endproperty
  a_last: assert property (p_last) else $error("completion sequence wrong");

  property p_stop;
    prog_bad |=> idle && err_bit ##1 idle;
  endproperty
  a_stop: assert property (p_stop) else $error("write continued after error");

  property p_hold;
    prog_bad |=> {drv_head[3:0], cyl_hi, cyl_lo, sec_num} == $past(cur_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("failing address lost");

  property p_legal_err;
    (error_flags & ~WR_ERR_MASK) == 8'h00 && !status_flags[ST_CORR];
  endproperty
  a_legal_err: assert property (p_legal_err) else $error("illegal write error bit");

  property p_bad_op;
    bad_op |=> error_flags == ABRT_CODE && status_flags[ST_ERR] && status_flags[ST_DRDY];
  endproperty
  a_bad_op: assert property (p_bad_op) else $error("bad opcode not aborted");

  property p_count;
    go |=> remaining == (($past(sec_cnt) == 8'h00) ? MAX_SECTORS : {1'b0, $past(sec_cnt)});
  endproperty
  a_count: assert property (p_count) else $error("sector count wrong");

  property p_erase;
    sector_full |=> wr_erase_o == !($past(no_erase) && $past(sector_erased_i));
  endproperty
  a_erase: assert property (p_erase) else $error("erase choice wrong");

  property p_err_bit;
    err_bit == (error_flags != 8'h00);
  endproperty
  a_err_bit: assert property (p_err_bit) else $error("error status mismatch");

  // Interrupt line follows the unmasked sticky bits with no extra lag
  property p_irq_line;
    irq_o == |(irq_sts & irq_mask);
  endproperty
  a_irq_line: assert property (p_irq_line) else $error("interrupt line wrong");

  // Address fields move only after a clean, non-final sector while busy
  property p_addr_hold;
    !idle && !(prog_ok && !last_sector) |=> $stable(sec_num);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved mid-sector");

endmodule : ata_sector_write_commands

/* hw/ata_wr_pkg.sv */
package ata_wr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_DATA = 4'h0;
  localparam logic [3:0] IDX_FEATURE = 4'h1;
  localparam logic [3:0] IDX_SEC_CNT = 4'h2;
  localparam logic [3:0] IDX_SEC_NUM = 4'h3;
  localparam logic [3:0] IDX_CYL_LO = 4'h4;
  localparam logic [3:0] IDX_CYL_HI = 4'h5;
  localparam logic [3:0] IDX_DRV_HEAD = 4'h6;
  localparam logic [3:0] IDX_CMD = 4'h7;
  localparam logic [3:0] IDX_ERROR = 4'h8;
  localparam logic [3:0] IDX_STATUS = 4'h9;
  localparam logic [3:0] IDX_IRQ_STS = 4'hA;
  localparam logic [3:0] IDX_IRQ_MASK = 4'hB;
  localparam int IDX_LSB = 2;
  // Opcodes
  localparam logic [7:0] OP_WR_NO_ERASE = 8'h38;
  localparam logic [7:0] OP_WR_VERIFY = 8'h3C;
  // Error flag positions
  localparam int ERR_BBK = 7;
  localparam int ERR_UNC = 6;
  localparam int ERR_IDNF = 4;
  localparam int ERR_ABRT = 2;
  localparam int ERR_AMNF = 0;
  localparam logic [7:0] WR_ERR_MASK = 8'h95;
  localparam logic [7:0] ABRT_CODE = 8'h04;
  // Status flag positions
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DWF = 5;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_CORR = 2;
  localparam int ST_ERR = 0;
  // Drive/head register fields
  localparam int DH_LBA = 6;
  // Interrupt status bits
  localparam int IRQ_DRQ = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_W = 2;
  // Transfer length limits
  localparam logic [8:0] MAX_SECTORS = 9'h100;
  localparam logic [8:0] ONE_SECTOR = 9'h001;
  // Command sequencer states, Gray along the path except done back to idle
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ACCEPT = 3'h1,
    ST_FILL = 3'h3,
    ST_PROG = 3'h2,
    ST_DONE = 3'h6
  } state_e;
endpackage : ata_wr_pkg

/* dv/flash_engine_model.sv */
`timescale 1ns/1ps
module flash_engine_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Requests from the block
  input wire logic wr_req_i,
  input wire logic wr_erase_i,
  input wire logic wr_chs_i,
  input wire logic [27:0] wr_addr_i,
  // Bench controls
  input wire logic erased_i,
  input wire logic [7:0] delay_i,
  input wire logic [15:0] fail_at_i,
  input wire logic [7:0] err_code_i,
  // Answers to the block
  output logic sector_erased_o,
  output logic wr_done_o,
  output logic [7:0] wr_err_o,
  // Observation for the bench
  output logic [15:0] req_count_o,
  output logic last_erase_o,
  output logic last_chs_o,
  output logic [27:0] last_addr_o
);
  logic [8:0] timer;
  logic [7:0] err_now;

  // Pre-erased state of the target sectors, chosen by the bench
  assign sector_erased_o = erased_i;
  // Code only counts with the done pulse; elsewhere show junk, not a stale value
  assign wr_err_o = wr_done_o ? err_now : ~err_now;

  // Latch each request and answer after a programmable delay
  always_ff @(posedge clk_i) begin
    wr_done_o <= 1'b0;
    if (!rst_b_i) begin
      timer <= 9'h000;
      err_now <= 8'h00;
      req_count_o <= 16'h0000;
    end else if (wr_req_i) begin
      req_count_o <= req_count_o + 16'h0001;
      last_erase_o <= wr_erase_i;
      last_chs_o <= wr_chs_i;
      last_addr_o <= wr_addr_i;
      timer <= {1'b0, delay_i} + 9'h001;
    end else if (timer != 9'h000) begin
      timer <= timer - 9'h001;
      if (timer == 9'h001) begin
        wr_done_o <= 1'b1;
        err_now <= (req_count_o == fail_at_i) ? err_code_i : 8'h00;
      end
    end
  end
endmodule : flash_engine_model

/* dv/tb_ata_sector_write_commands.sv */
`timescale 1ns/1ps
module tb_ata_sector_write_commands;
  import ata_wr_pkg::*;
  localparam int SW = 4;
  logic clk_i, rst_b_i, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd, wr_data;
  logic [1:0] htrans;
  logic wr_req, wr_erase, wr_chs, wr_dv, erased, erase_pre, done, last_erase, last_chs;
  logic [27:0] wr_addr, last_addr;
  logic [7:0] wr_err, err_code, delay;
  logic [15:0] fail_at, req_count, base, words_seen;
  int bad_count = 0;
  int checks_done = 0;

  ata_sector_write_commands #(.SECTOR_WORDS(SW)) DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .irq_o(irq),
    .wr_req_o(wr_req), .wr_erase_o(wr_erase), .wr_chs_o(wr_chs), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .wr_data_valid_o(wr_dv), .sector_erased_i(erased), .wr_done_i(done), .wr_err_i(wr_err));

  flash_engine_model flash (.clk_i(clk_i), .rst_b_i(rst_b_i), .wr_req_i(wr_req), .wr_erase_i(wr_erase),
    .wr_chs_i(wr_chs), .wr_addr_i(wr_addr), .erased_i(erase_pre), .delay_i(delay), .fail_at_i(fail_at),
    .err_code_i(err_code), .sector_erased_o(erased), .wr_done_o(done), .wr_err_o(wr_err),
    .req_count_o(req_count), .last_erase_o(last_erase), .last_chs_o(last_chs), .last_addr_o(last_addr));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Look at hready mid-cycle so the next edge is the one that samples it
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge clk_i);
    while (hreadyout !== 1'b1 && n < 1000) begin
      @(negedge clk_i);
      n++;
    end
  endtask : wait_ready

  // One AHB single transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [3:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {26'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    @(posedge clk_i);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
    @(posedge clk_i);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, {24'h0, d});
  endtask : wr

  task automatic rdchk(input logic [3:0] idx, input logic [7:0] e, input string what);
    xfer(1'b0, idx, 32'h0);
    check(what, rd, {24'h0, e});
  endtask : rdchk

  // Bounded poll of the status register until the masked bits match
  task automatic poll(input logic [7:0] m, input logic [7:0] v);
    int n;
    n = 0;
    do begin
      xfer(1'b0, IDX_STATUS, 32'h0);
      n++;
    end while ((rd[7:0] & m) !== v && n < 400);
    check("status poll", {24'h0, rd[7:0] & m}, {24'h0, v});
  endtask : poll

  task automatic setup(input logic [7:0] cnt, sn, cl, ch, dh, op);
    wr(IDX_SEC_CNT, cnt);
    wr(IDX_SEC_NUM, sn);
    wr(IDX_CYL_LO, cl);
    wr(IDX_CYL_HI, ch);
    wr(IDX_DRV_HEAD, dh);
    base = req_count;
    wr(IDX_CMD, op);
  endtask : setup

  // Data goes only once DRQ is up and BSY down
  task automatic send_sector();
    poll(8'h88, 8'h08);
    for (int i = 0; i < SW; i++) xfer(1'b1, IDX_DATA, 32'hA5A50000 + i);
  endtask : send_sector

  task automatic t_reset();
    rdchk(IDX_STATUS, 8'h50, "status reset");
    rdchk(IDX_ERROR, 8'h00, "error reset");
    rdchk(IDX_SEC_CNT, 8'h01, "count reset");
    rdchk(IDX_DRV_HEAD, 8'hA0, "drive head reset");
    rdchk(IDX_CMD, 8'h00, "command reads zero");
    wr(IDX_FEATURE, 8'h5A);
    rdchk(IDX_FEATURE, 8'h5A, "feature");
    // Data word while idle must be refused; the word count later shows it
    wr(IDX_DATA, 8'h3C);
    wr(4'hC, 8'h5A);
    rdchk(4'hC, 8'h00, "unmapped");
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask : t_reset

  task automatic t_bad_opcode();
    wr(IDX_IRQ_MASK, 8'h03);
    wr(IDX_CMD, 8'h77);
    rdchk(IDX_ERROR, ABRT_CODE, "abort code");
    rdchk(IDX_STATUS, 8'h51, "abort status");
    rdchk(IDX_IRQ_STS, 8'h02, "abort irq");
    check("irq up", {31'h0, irq}, 32'h1);
    wr(IDX_IRQ_STS, 8'h03);
    rdchk(IDX_IRQ_STS, 8'h00, "abort irq cleared");
    check("irq cleared", {31'h0, irq}, 32'h0);
  endtask : t_bad_opcode

  task automatic t_no_erase_two();
    erase_pre <= 1'b1;
    delay <= 8'd20;
    setup(8'h02, 8'h10, 8'h22, 8'h33, 8'hE5, OP_WR_NO_ERASE);
    rdchk(IDX_ERROR, 8'h00, "error cleared on accept");
    rdchk(IDX_STATUS, 8'h58, "first fill");
    rdchk(IDX_IRQ_STS, 8'h00, "no first irq");
    send_sector();
    rdchk(IDX_STATUS, 8'hD0, "sector taken");
    poll(8'h88, 8'h08);
    rdchk(IDX_IRQ_STS, 8'h01, "next buffer irq");
    check("irq next", {31'h0, irq}, 32'h1);
    check("no erase", {31'h0, last_erase}, 32'h0);
    check("lba mode", {31'h0, last_chs}, 32'h0);
    check("start addr", {4'h0, last_addr}, 32'h05332210);
    send_sector();
    rdchk(IDX_STATUS, 8'hD0, "last held busy");
    poll(8'hFF, 8'h50);
    check("next addr", {4'h0, last_addr}, 32'h05332211);
    check("last word", wr_data, 32'hA5A50000 + SW - 1);
    check("words taken", {16'h0, words_seen}, 32'd8);
    rdchk(IDX_IRQ_STS, 8'h03, "done irq");
    wr(IDX_IRQ_STS, 8'h03);
  endtask : t_no_erase_two

  task automatic t_fallback_masked();
    erase_pre <= 1'b0;
    wr(IDX_IRQ_MASK, 8'h00);
    setup(8'h01, 8'h01, 8'h00, 8'h00, 8'hE0, OP_WR_NO_ERASE);
    send_sector();
    poll(8'hFF, 8'h50);
    check("erase fallback", {31'h0, last_erase}, 32'h1);
    rdchk(IDX_IRQ_STS, 8'h02, "done pending");
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(IDX_IRQ_STS, 8'h03);
  endtask : t_fallback_masked

  task automatic t_verify_max();
    erase_pre <= 1'b1;
    delay <= 8'd2;
    setup(8'h00, 8'h00, 8'h00, 8'h00, 8'hE0, OP_WR_VERIFY);
    repeat (256) send_sector();
    poll(8'hFF, 8'h50);
    check("sector total", {16'h0, req_count - base}, 32'd256);
    check("verify erases", {31'h0, last_erase}, 32'h1);
    wr(IDX_IRQ_STS, 8'h03);
  endtask : t_verify_max

  task automatic t_error_chs();
    delay <= 8'd3;
    err_code <= 8'hD1;
    fail_at <= req_count + 16'd2;
    setup(8'h03, 8'd32, 8'h00, 8'h00, 8'hA0, OP_WR_VERIFY);
    send_sector();
    send_sector();
    poll(8'hFF, 8'h51);
    rdchk(IDX_ERROR, 8'h91, "write error set");
    rdchk(IDX_SEC_NUM, 8'h01, "failing sector");
    rdchk(IDX_DRV_HEAD, 8'hA1, "failing head");
    check("stopped", {16'h0, req_count - base}, 32'd2);
    check("chs mode", {31'h0, last_chs}, 32'h1);
    fail_at <= 16'h0;
  endtask : t_error_chs

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // Count data words handed to the flash engine
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) words_seen <= 16'h0000;
    else if (wr_dv) words_seen <= words_seen + 16'h0001;
  end

  // Free-running bus clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Hang guard, well above the longest sequence
  initial begin
    repeat (80000) @(posedge clk_i);
    bad_count++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    rst_b_i = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {erase_pre, delay, fail_at, err_code} = '0;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_reset();
    t_bad_opcode();
    t_no_erase_two();
    t_fallback_masked();
    t_verify_max();
    t_error_chs();
    report_and_stop();
  end
endmodule : tb_ata_sector_write_commands
